/* File: src/csr_top.sv */
// scaler dataway command decoder with memory readback and indicators
`timescale 1ns/1ps
// What this block does
// - setup subaddress 1-8 steps n times channels
// - setup subaddress 9-15 acts as one
// - setup word low twenty bits give start
// - data read returns word, then steps address
// - data read zeroes high lines, Q=1 X=1
// - past memory end: Q=0 X=1, zeroes
// - data read outside readback refused, zeroes
// - status reads honoured always with Q=1
// - status: mode, overflow switch, memory full
// - memory read returns module count switch
// - channel read returns active channel switch
// - enable counter read on twenty lines
// - identity read returns fixed code
// - clear or initialize forces standby
// - address indicator flashes 100 ms
// - response indicator flashes when Q=1
// - armed and readback mode indicators lit
// - readback activity lit at least 100 ms
// - switch counts shown on indicator groups
// - setup enters readback; subaddress zero steps one
// - standby and arm clear counter and full
// - memory end in armed sets full, no wrap
module csr_top #(
    parameter int          FLASH_CYCLES = csr_pkg::FLASH_CYC,
    parameter logic [23:0] MODULE_ID    = csr_pkg::MODULE_ID_DEFAULT,
    parameter int          BUF_DEPTH    = 2
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // dataway command, valid held until taken with cmd_ready
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [4:0]  cmd_func,
    input  wire logic [3:0]  cmd_sub,
    input  wire logic [23:0] cmd_wdata,
    input  wire logic        dw_clear,
    input  wire logic        dw_init,
    // dataway answer
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic [23:0]      rsp_rdata,
    output logic             rsp_q,
    output logic             rsp_x,
    // switches, count front end and memory
    input  wire logic [4:0]  sw_channels,
    input  wire logic [4:0]  sw_modules,
    input  wire logic        sw_overflow,
    input  wire logic        ce_pulse,
    input  wire logic        mem_store,
    output logic [19:0]      mem_addr,
    input  wire logic [11:0] mem_rdata,
    output logic             store_enable,
    // indicators
    output logic             led_addressed,
    output logic             led_response,
    output logic             led_armed,
    output logic             led_readback,
    output logic             readback_activity_indicator,
    output logic [4:0]       led_channels,
    output logic [4:0]       led_modules
);
    import csr_pkg::*;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // switch synchronisers, three stages, change once last two agree
    // ****************************************************************
    logic [12:0] sw_s1_q, sw_s2_q, sw_s3_q, sw_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sw_s1_q <= 13'h0000;
            sw_s2_q <= 13'h0000;
            sw_s3_q <= 13'h0000;
            sw_q    <= 13'h0000;
        end else begin
            sw_s1_q <= {dw_init, dw_clear, sw_overflow, sw_modules, sw_channels};
            sw_s2_q <= sw_s1_q;
            sw_s3_q <= sw_s2_q;
            for (int i = 0; i < 13; i++) begin
                if (sw_s2_q[i] == sw_s3_q[i]) begin
                    sw_q[i] <= sw_s3_q[i];
                end
            end
        end
    end
    logic [4:0] chans;
    logic [4:0] mods;
    logic       ovf_sw;
    logic       cz;
    assign chans  = sw_q[4:0];
    assign mods   = sw_q[9:5];
    assign ovf_sw = sw_q[10];
    assign cz     = sw_q[11] | sw_q[12];

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic is_cmd(input logic [4:0] f, input logic [3:0] a,
                                    input logic [4:0] wf, input logic [3:0] wa);
        return (f == wf) && (a == wa);
    endfunction

    logic take;
    logic do_setup, do_standby, do_arm, do_data;
    assign take       = cmd_valid & cmd_ready;
    assign do_setup   = take & (cmd_func == FN_SETUP);
    assign do_standby = take & is_cmd(cmd_func, cmd_sub, FN_STANDBY, SA_DATA);
    assign do_arm     = take & is_cmd(cmd_func, cmd_sub, FN_ARM, SA_DATA);
    assign do_data    = take & is_cmd(cmd_func, cmd_sub, FN_READ, SA_DATA);

    // ****************************************************************
    // mode
    // ****************************************************************
    csr_mode_e mode_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_q <= CSR_STANDBY;
        end else if (cz) begin
            mode_q <= CSR_STANDBY;
        end else if (do_setup) begin
            mode_q <= CSR_READBACK;
        end else if (do_arm) begin
            mode_q <= CSR_ARMED;
        end else if (do_standby) begin
            mode_q <= CSR_STANDBY;
        end
    end

    // ****************************************************************
    // readback address, step and end-of-memory compare
    // ****************************************************************
    logic [19:0] addr_q;
    logic [8:0]  step_q;
    logic [20:0] mem_limit;
    logic        in_range_q;
    logic [3:0]  mult;
    assign mult      = (cmd_sub > SA_MAX_MULT) ? 4'h1 : cmd_sub;
    assign mem_limit = {1'b0, mods, 15'h0000};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            step_q <= 9'h001;
        end else if (do_setup) begin
            if (cmd_sub == SA_DATA) begin
                step_q <= 9'h001;
            end else begin
                step_q <= {5'h00, mult} * {4'h0, chans};
            end
        end
    end

    logic [19:0] store_addr_q;
    logic        full_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_q <= 20'h00000;
        end else if (do_setup) begin
            addr_q <= cmd_wdata[ADDR_W-1:0];
        end else if (do_data && mode_q == CSR_READBACK && in_range_q) begin
            addr_q <= addr_q + 20'(step_q);
        end
    end
    // registered compare: settled one cycle after every address change, and commands are one every two cycles at most
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_range_q <= 1'b0;
        end else begin
            in_range_q <= {1'b0, addr_q} < mem_limit;
        end
    end
    assign mem_addr = (mode_q == CSR_READBACK) ? addr_q : store_addr_q;

    // ****************************************************************
    // armed storage address, memory full, enable counter
    // ****************************************************************
    logic [19:0] ce_count_q;
    assign store_enable = (mode_q == CSR_ARMED) & ~full_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            store_addr_q <= 20'h00000;
            full_q       <= 1'b0;
        end else if (do_arm || do_standby) begin
            store_addr_q <= 20'h00000;
            full_q       <= 1'b0;
        end else if (store_enable && mem_store) begin
            if ({1'b0, store_addr_q} + 21'h000001 >= mem_limit) begin
                full_q <= 1'b1;
            end else begin
                store_addr_q <= store_addr_q + 20'h00001;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ce_count_q <= 20'h00000;
        end else if (do_arm || do_standby || mode_q == CSR_STANDBY) begin
            ce_count_q <= 20'h00000;
        end else if (store_enable && ce_pulse) begin
            ce_count_q <= ce_count_q + 20'h00001;
        end
    end

    // ****************************************************************
    // answer word and Q; two-entry buffer toward the dataway
    // ****************************************************************
    logic [23:0] ans_data;
    logic        ans_q;
    always_comb begin
        ans_data = 24'h000000;
        ans_q    = 1'b1;
        if (cmd_func == FN_READ_ID && cmd_sub == SA_DATA) begin
            ans_data = MODULE_ID;
        end else if (cmd_func == FN_READ) begin
            unique case (cmd_sub)
                SA_DATA: begin
                    if (mode_q == CSR_READBACK && in_range_q) begin
                        ans_data = {12'h000, mem_rdata};
                    end else begin
                        ans_q = 1'b0;
                    end
                end
                SA_CE_COUNT:   ans_data = {4'h0, ce_count_q};
                SA_STATUS: begin
                    ans_data[STAT_MODE_LSB+:2] = (mode_q == CSR_READBACK) ? 2'b10 :
                                                 (mode_q == CSR_ARMED) ? 2'b01 : 2'b00;
                    ans_data[STAT_OVF_BIT]     = ovf_sw;
                    ans_data[STAT_FULL_BIT]    = full_q;
                end
                SA_MEM_COUNT:  ans_data = {19'h00000, mods};
                SA_CHAN_COUNT: ans_data = {19'h00000, chans};
                default:       ans_q = 1'b0;
            endcase
        end else if (!(cmd_func == FN_SETUP || cmd_func == FN_STANDBY || cmd_func == FN_ARM)) begin
            ans_q = 1'b0;
        end
    end

    logic [25:0] buf_q [BUF_DEPTH];
    logic [1:0]  cnt_q;
    logic        rd_ptr_q, wr_ptr_q;
    assign cmd_ready = (cnt_q != 2'(BUF_DEPTH));
    assign rsp_valid = (cnt_q != 2'h0);
    logic pop;
    assign pop = rsp_valid & rsp_ready;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q    <= 2'h0;
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_q[i] <= 26'h0000000;
            end
        end else begin
            if (take) begin
                buf_q[wr_ptr_q] <= {1'b1, ans_q, ans_data};
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + 2'(take) - 2'(pop);
        end
    end
    assign rsp_rdata = buf_q[rd_ptr_q][23:0];
    assign rsp_q     = buf_q[rd_ptr_q][24];
    assign rsp_x     = buf_q[rd_ptr_q][25];

    // ****************************************************************
    // indicators; retriggered stretchers so a burst keeps the lamp lit
    // ****************************************************************
    logic [22:0] n_cnt_q, q_cnt_q, rb_cnt_q;
    function automatic logic [22:0] stretch(input logic ev, input logic [22:0] c);
        if (ev) begin
            return 23'(FLASH_CYCLES);
        end
        return (c != 23'h000000) ? c - 23'h000001 : c;
    endfunction
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            n_cnt_q  <= 23'h000000;
            q_cnt_q  <= 23'h000000;
            rb_cnt_q <= 23'h000000;
        end else begin
            n_cnt_q  <= stretch(take, n_cnt_q);
            q_cnt_q  <= stretch(take & ans_q, q_cnt_q);
            rb_cnt_q <= stretch(do_data & ans_q, rb_cnt_q);
        end
    end
    assign led_addressed               = (n_cnt_q != 23'h000000);
    assign led_response                = (q_cnt_q != 23'h000000);
    assign readback_activity_indicator = (rb_cnt_q != 23'h000000) | (do_data & ans_q);
    assign led_armed                   = (mode_q == CSR_ARMED);
    assign led_readback                = (mode_q == CSR_READBACK);
    assign led_channels                = chans;
    assign led_modules                 = mods;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_setup;
        do_setup && cmd_sub == 4'h0;
    endsequence
    sequence s_data_ok;
        do_data && mode_q == CSR_READBACK && in_range_q;
    endsequence
    sequence s_data_bad;
        do_data && mode_q == CSR_READBACK && !in_range_q;
    endsequence
    sequence s_status;
        take && cmd_func == FN_READ && cmd_sub != SA_DATA && cmd_sub <= SA_CHAN_COUNT;
    endsequence
    a_clear_standby: assert property (
        cz |=> mode_q == CSR_STANDBY)
        else $error("clear did not force standby");
    a_setup_mode: assert property (
        do_setup && !cz |=> mode_q == CSR_READBACK)
        else $error("setup did not enter readback");
    a_step_one: assert property (
        s_setup |=> step_q == 9'h001)
        else $error("subaddress zero step wrong");
    a_step_mult: assert property (
        do_setup && cmd_sub > 4'h8 |=> step_q == {4'h0, $past(chans)})
        else $error("high sub step wrong");
    a_step_scaled: assert property (
        do_setup && cmd_sub != 4'h0 && cmd_sub <= 4'h8
        |=> step_q == {5'h00, $past(cmd_sub)} * {4'h0, $past(chans)})
        else $error("scaled step wrong");
    a_start_addr: assert property (
        do_setup |=> addr_q == 20'($past(cmd_wdata)))
        else $error("start address not loaded");
    a_refuse_data: assert property (
        do_data && mode_q != CSR_READBACK |-> !ans_q && ans_data == 24'h000000)
        else $error("data read not refused");
    a_data_word: assert property (
        s_data_ok |-> ans_q && ans_data == {12'h000, mem_rdata})
        else $error("data word or high lines wrong");
    a_range_refuse: assert property (
        s_data_bad |-> !ans_q && ans_data == 24'h000000)
        else $error("out of range read not refused");
    a_addr_step: assert property (
        s_data_ok |=> addr_q == $past(addr_q) + 20'($past(step_q)))
        else $error("address did not step");
    a_status_q: assert property (
        s_status |-> ans_q)
        else $error("status read not honoured");
    a_status_high: assert property (
        take && is_cmd(cmd_func, cmd_sub, FN_READ, SA_STATUS) |-> ans_data[23:4] == 20'h00000)
        else $error("status high bits set");
    a_mem_word: assert property (
        take && is_cmd(cmd_func, cmd_sub, FN_READ, SA_MEM_COUNT) |-> ans_data[23:5] == 19'h00000)
        else $error("memory count high bits set");
    a_chan_word: assert property (
        take && is_cmd(cmd_func, cmd_sub, FN_READ, SA_CHAN_COUNT) |-> ans_data[23:5] == 19'h00000)
        else $error("channel count high bits set");
    a_ce_word: assert property (
        take && is_cmd(cmd_func, cmd_sub, FN_READ, SA_CE_COUNT) |-> ans_q && ans_data[23:20] == 4'h0)
        else $error("enable counter word wrong");
    a_id_word: assert property (
        take && is_cmd(cmd_func, cmd_sub, FN_READ_ID, SA_DATA) |-> ans_q && ans_data == MODULE_ID)
        else $error("identity word wrong");
    a_answer_x: assert property (
        rsp_valid |-> rsp_x)
        else $error("answer without x");
    a_full_clear: assert property (
        do_arm |=> !full_q && ce_count_q == 20'h00000)
        else $error("arm did not clear");
    a_full_hold: assert property (
        full_q && !do_arm && !do_standby |=> full_q && store_addr_q == $past(store_addr_q))
        else $error("full memory address moved");
    a_flash_on: assert property (
        take |=> led_addressed [*8])
        else $error("address lamp too short");
    a_resp_lamp: assert property (
        take && ans_q |=> led_response)
        else $error("response lamp not lit");
    a_rb_lamp: assert property (
        do_data && ans_q |-> readback_activity_indicator)
        else $error("readback lamp not lit");
    a_mode_lamps: assert property (
        !(led_armed && led_readback))
        else $error("both mode lamps lit");
endmodule

/* File: pkg/csr_pkg.sv */
// constants and types for the scaler command and readback block
package csr_pkg;
    // ****************************************************************
    // functions and subaddresses
    // ****************************************************************
    localparam logic [4:0] FN_READ       = 5'h00;
    localparam logic [4:0] FN_READ_ID    = 5'h06;
    localparam logic [4:0] FN_SETUP      = 5'h11;
    localparam logic [4:0] FN_STANDBY    = 5'h18;
    localparam logic [4:0] FN_ARM        = 5'h1a;
    localparam logic [3:0] SA_DATA       = 4'h0;
    localparam logic [3:0] SA_CE_COUNT   = 4'h1;
    localparam logic [3:0] SA_STATUS     = 4'h2;
    localparam logic [3:0] SA_MEM_COUNT  = 4'h3;
    localparam logic [3:0] SA_CHAN_COUNT = 4'h4;
    localparam logic [3:0] SA_MAX_MULT   = 4'h8;
    // ****************************************************************
    // field layout and sizes
    // ****************************************************************
    localparam int         ADDR_W        = 20;
    localparam int         DATA_W        = 24;
    localparam int         WORD_W        = 12;
    localparam int         MOD_WORDS_LOG = 15;
    localparam int         STAT_MODE_LSB = 0;
    localparam int         STAT_OVF_BIT  = 2;
    localparam int         STAT_FULL_BIT = 3;
    // arbitrary neutral identification value
    localparam logic [23:0] MODULE_ID_DEFAULT = 24'h00a5c3;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int         CLK_HZ        = 20000000;
    localparam int         FLASH_MS      = 100;
    localparam int         FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;
    localparam logic [1:0] SYNC_RST      = 2'h0;
    // ****************************************************************
    // modes, gray along standby, armed, readback
    // ****************************************************************
    typedef enum logic [1:0] {
        CSR_STANDBY  = 2'b00,
        CSR_ARMED    = 2'b01,
        CSR_READBACK = 2'b11
    } csr_mode_e;
endpackage

/* File: tb/csr_crate_model.sv */
// crate controller model: issues dataway commands and collects the answers
`timescale 1ns/1ps
module csr_crate_model (
    // clock
    input  wire logic        clock,
    // command side
    output logic             cmd_valid,
    input  wire logic        cmd_ready,
    output logic [4:0]       cmd_func,
    output logic [3:0]       cmd_sub,
    output logic [23:0]      cmd_wdata,
    // answer side
    input  wire logic        rsp_valid,
    output logic             rsp_ready,
    input  wire logic [23:0] rsp_rdata,
    input  wire logic        rsp_q,
    input  wire logic        rsp_x,
    // stall control
    input  wire logic        hold,
    input  wire logic        slow
);
    logic [25:0] got[$];
    logic        tick;
    initial begin
        cmd_valid = 1'b0;
        cmd_func  = 5'h00;
        cmd_sub   = 4'h0;
        cmd_wdata = 24'h000000;
        rsp_ready = 1'b0;
        tick      = 1'b0;
    end
    // one command, held until ready is seen at a falling edge
    task automatic issue(input logic [4:0] f, input logic [3:0] s, input logic [19:0] w);
        @(posedge clock);
        cmd_func  <= f;
        cmd_sub   <= s;
        cmd_wdata <= {4'h0, w};
        cmd_valid <= 1'b1;
        @(negedge clock);
        while (cmd_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        cmd_valid <= 1'b0;
        // released lines show garbage, not the old command
        cmd_func  <= ~f;
        cmd_sub   <= ~s;
        cmd_wdata <= ~{4'h0, w};
    endtask
    always @(posedge clock) begin
        tick      <= ~tick;
        rsp_ready <= !hold && (!slow || tick);
    end
    // sampled mid-cycle so the pop edge sees exactly this state
    always @(negedge clock) begin
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1) got.push_back({rsp_q, rsp_x, rsp_rdata});
    end
endmodule

/* File: tb/csr_top_test.sv */
// self-checking bench for the scaler command and readback block
`timescale 1ns/1ps
module csr_top_test;
    import csr_pkg::*;
    localparam int          FLASH = 20;
    localparam logic [23:0] ID    = 24'h3c5a96; // arbitrary identity value
    logic        clock, rst_n, cmd_valid, cmd_ready, dw_clear, dw_init, rsp_valid, rsp_ready;
    logic        rsp_q, rsp_x, sw_overflow, ce_pulse, mem_store, store_enable, hold, slow;
    logic        led_addressed, led_response, led_armed, led_readback, readback_activity_indicator;
    logic [4:0]  cmd_func, sw_channels, sw_modules, led_channels, led_modules;
    logic [3:0]  cmd_sub;
    logic [23:0] cmd_wdata, rsp_rdata;
    logic [19:0] mem_addr;
    logic [11:0] mem_rdata;
    logic [31:0] seed;
    logic [26:0] exp_q[$];
    int          fails, num_checks, mode, addr, step, full, ce_cnt, ch, mods, k, s;
    csr_top #(.FLASH_CYCLES(FLASH), .MODULE_ID(ID), .BUF_DEPTH(2)) dut (
        .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_func(cmd_func), .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .dw_clear(dw_clear),
        .dw_init(dw_init), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_rdata(rsp_rdata),
        .rsp_q(rsp_q), .rsp_x(rsp_x), .sw_channels(sw_channels), .sw_modules(sw_modules),
        .sw_overflow(sw_overflow), .ce_pulse(ce_pulse), .mem_store(mem_store), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .store_enable(store_enable), .led_addressed(led_addressed),
        .led_response(led_response), .led_armed(led_armed), .led_readback(led_readback),
        .readback_activity_indicator(readback_activity_indicator), .led_channels(led_channels),
        .led_modules(led_modules));
    csr_crate_model crate (
        .clock(clock), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_func(cmd_func),
        .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_rdata(rsp_rdata), .rsp_q(rsp_q), .rsp_x(rsp_x), .hold(hold), .slow(slow));
    // memory contents are a fixed function of the address
    assign mem_rdata = mem_addr[11:0] ^ mem_addr[19:8];
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic bad(input string m);
        fails++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic cmp_rsp(input logic [25:0] g, input logic [26:0] e);
        num_checks++;
        if (g[25:24] !== e[25:24] || (e[26] && g[23:0] !== e[23:0])) bad($sformatf("answer %h not %h", g, e));
    endtask
    task automatic cmp_flag(input logic [4:0] g, input logic [4:0] e);
        #1;
        num_checks++;
        if (g !== e) bad($sformatf("flag %h not %h", g, e));
    endtask
    // reference model: expected answer from mode, address and switches
    task automatic cmd(input logic [4:0] f, input logic [3:0] sa, input logic [19:0] wd);
        logic [26:0] e;
        logic [11:0] m;
        e = {(f == FN_READ || f == FN_READ_ID), 2'b01, 24'h0};
        m = 12'(addr) ^ 12'(addr >> 8);
        if (f == FN_SETUP) begin
            mode = 2;
            addr = int'(wd);
            step = (sa == 4'h0) ? 1 : (sa <= SA_MAX_MULT) ? int'(sa) * ch : ch;
            e[25] = 1'b1;
        end else if (f == FN_STANDBY || f == FN_ARM) begin
            mode = (f == FN_ARM) ? 1 : 0;
            ce_cnt = 0;
            full = 0;
            e[25] = 1'b1;
        end else if (f == FN_READ_ID && sa == 4'h0) e[25:0] = {2'b11, ID};
        else if (f == FN_READ) begin
            case (sa)
                SA_DATA: if (mode == 2 && addr < mods * 32768) begin
                    e[25:0] = {2'b11, 12'h0, m};
                    addr = addr + step;
                end
                SA_CE_COUNT: e[25:0] = {2'b11, 24'(ce_cnt)};
                SA_STATUS: e[25:0] = {2'b11, 20'h0, 1'(full), sw_overflow, 2'(mode)};
                SA_MEM_COUNT: e[25:0] = {2'b11, 19'h0, sw_modules};
                SA_CHAN_COUNT: e[25:0] = {2'b11, 19'h0, sw_channels};
                default: e[25:0] = {2'b01, 24'h0};
            endcase
        end
        exp_q.push_back(e);
        crate.issue(f, sa, wd);
    endtask
    task automatic drain(input int n);
        logic [25:0] g;
        int t;
        repeat (n) begin
            t = 0;
            while (crate.got.size() == 0 && t < 100) begin
                @(posedge clock);
                t++;
            end
            g = (crate.got.size() > 0) ? crate.got.pop_front() : 26'h0;
            cmp_rsp(g, exp_q.pop_front());
        end
    endtask
    task automatic run(input logic [4:0] f, input logic [3:0] sa, input logic [19:0] wd);
        cmd(f, sa, wd);
        drain(1);
    endtask
    task automatic pulse_ce(input int n);
        logic [31:0] r;
        repeat (n) begin
            @(posedge clock);
            r = rnd();
            ce_pulse <= ~ce_pulse & r[0];
            if (!ce_pulse && r[0] && mode == 1 && full == 0) ce_cnt++;
        end
        @(posedge clock);
        ce_pulse <= 1'b0;
    endtask
    task automatic results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        bad("watchdog expired");
        results();
    end
    initial begin
        seed = 32'hc7f3;
        {rst_n, dw_clear, dw_init, sw_overflow, ce_pulse, mem_store, hold, slow} = 8'h00;
        sw_channels = 5'(rnd() % 31 + 1);
        sw_modules = 5'h01;
        ch = int'(sw_channels);
        mods = 1;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        cmp_flag(rsp_valid, 0);
        cmp_flag(cmd_ready, 1);
        cmp_flag(led_channels, sw_channels);
        cmp_flag(led_modules, sw_modules);
        repeat (30) @(posedge clock);
        cmp_flag(led_addressed, 0);
        run(FN_READ, SA_DATA, 20'h0);
        cmp_flag(led_addressed, 1);
        cmp_flag(led_response, 0);
        for (k = 0; k < 6; k++) run(k < 5 ? FN_READ : FN_READ_ID, 4'(k < 5 ? k : 0), 20'h0);
        cmp_flag(led_response, 1);
        run(5'h01, 4'h0, 20'h0);
        for (k = 0; k < 2; k++) begin
            sw_overflow <= ~sw_overflow;
            repeat (8) @(posedge clock);
            run(FN_READ, SA_STATUS, 20'h0);
        end
        run(FN_ARM, 4'h0, 20'h0);
        cmp_flag(led_armed, 1);
        run(FN_READ, SA_DATA, 20'h0);
        pulse_ce(200);
        run(FN_READ, SA_CE_COUNT, 20'h0);
        run(FN_READ, SA_STATUS, 20'h0);
        for (k = 0; k < 2; k++) begin
            run(FN_ARM, 4'h0, 20'h0);
            {dw_clear, dw_init} <= 2'(k + 1);
            repeat (4) @(posedge clock);
            {dw_clear, dw_init} <= 2'b00;
            repeat (8) @(posedge clock);
            mode = 0;
            run(FN_READ, SA_STATUS, 20'h0);
        end
        for (s = 0; s < 16; s++) begin
            run(FN_SETUP, 4'(s), 20'(s % 2 ? 32700 + rnd() % 60 : rnd() % 32768));
            cmp_flag({led_armed, led_readback}, 5'h01);
            repeat (3) run(FN_READ, SA_DATA, 20'h0);
            cmp_flag(readback_activity_indicator, 1);
        end
        run(FN_READ, SA_STATUS, 20'h0);
        hold <= 1'b1;
        repeat (2) cmd(FN_READ, SA_CHAN_COUNT, 20'h0);
        repeat (3) @(posedge clock);
        cmp_flag(cmd_ready, 0);
        hold <= 1'b0;
        slow <= 1'b1;
        cmd(FN_READ, SA_MEM_COUNT, 20'h0);
        drain(3);
        slow <= 1'b0;
        repeat (30) @(posedge clock);
        cmp_flag({led_addressed, led_response, readback_activity_indicator}, 0);
        run(FN_ARM, 4'h0, 20'h0);
        cmp_flag(store_enable, 1);
        mem_store <= 1'b1;
        repeat (32768) @(posedge clock);
        mem_store <= 1'b0;
        full = 1;
        repeat (3) @(posedge clock);
        cmp_flag(store_enable, 0);
        pulse_ce(20);
        run(FN_READ, SA_CE_COUNT, 20'h0);
        run(FN_READ, SA_STATUS, 20'h0);
        run(FN_STANDBY, 4'h0, 20'h0);
        run(FN_READ, SA_STATUS, 20'h0);
        results();
    end
endmodule
